/* File: rtl/mcr_monitor_ctrl.sv */
/*
  Control register, measurement sequencer, result formatting and result
  registers of the four-input monitor.
  Assumes a byte register port driven by the serial bus engine (reg_rd and
  reg_wr one-cycle pulses, synchronous to clk) and a converter front end that
  answers each held request with one conv_done pulse.
*/
`timescale 1ns/1ps
module mcr_monitor_ctrl #(
  parameter int RESULT_W = 14
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Converter front end
  output logic conv_req,
  output mcr_pkg::mcr_conv_req_t conv_cmd,
  input wire logic conv_done,
  input wire mcr_pkg::mcr_conv_res_t conv_res,
  // Status
  output logic busy
);
  import mcr_pkg::*;

  if (RESULT_W != VOLT_W) begin : g_width_check
    $error("mcr_monitor_ctrl: result layout needs RESULT_W of 14");
  end

  // ************************************************************
  // Slot selection helpers
  // ************************************************************
  function automatic logic slot_enabled(input logic [7:0] ctrl, input logic [2:0] slot);
    logic [1:0] pair;
    logic [2:0] set;
    logic en;
    pair = ctrl[CTRL_PAIR_HI:CTRL_PAIR_LO];
    set = ctrl[CTRL_SET_HI:CTRL_SET_LO];
    en = 1'b0;
    unique case (slot)
      SLOT_TINT: en = (pair == PAIR_TINT_ONLY) || (pair == PAIR_ALL);
      SLOT_IN1: en = (pair == PAIR_FIRST) || (pair == PAIR_ALL);
      SLOT_IN2: en = ((pair == PAIR_FIRST) || (pair == PAIR_ALL))
                     && ((set == 3'h0) || (set == 3'h7));
      SLOT_IN3: en = (pair == PAIR_SECOND) || (pair == PAIR_ALL);
      SLOT_IN4: en = ((pair == PAIR_SECOND) || (pair == PAIR_ALL))
                     && ((set == 3'h2) || (set == 3'h3) || (set == 3'h7));
      SLOT_VCC: en = (pair == PAIR_ALL);
      default: en = 1'b0;
    endcase
    return en;
  endfunction : slot_enabled

  function automatic mcr_kind_t slot_kind(input logic [7:0] ctrl, input logic [2:0] slot);
    logic [2:0] set;
    mcr_kind_t k;
    set = ctrl[CTRL_SET_HI:CTRL_SET_LO];
    k = MK_SINGLE;
    unique case (slot)
      SLOT_TINT: k = MK_TINT;
      SLOT_IN1: begin
        unique case (set)
          3'h0, 3'h7: k = MK_SINGLE;
          3'h1, 3'h2, 3'h6: k = MK_DIFF;
          default: k = MK_REMOTE;
        endcase
      end
      SLOT_IN3: begin
        unique case (set)
          3'h0, 3'h1, 3'h5: k = MK_REMOTE;
          3'h4, 3'h6: k = MK_DIFF;
          default: k = MK_SINGLE;
        endcase
      end
      SLOT_VCC: k = MK_SUPPLY;
      default: k = MK_SINGLE;
    endcase
    return k;
  endfunction : slot_kind

  // ************************************************************
  // Register port decode
  // ************************************************************
  logic [3:0] addr;
  logic [2:0] rd_slot;
  logic rd_result_hi;
  logic trigger_wr;

  // Upper address bits are ignored, so the map aliases every 16 bytes
  assign addr = reg_addr[3:0];
  assign rd_slot = addr[3:1] - SLOT_BASE;
  assign rd_result_hi = reg_rd && (addr >= ADDR_RESULT_FIRST) && !addr[0];
  assign trigger_wr = reg_wr && (addr == ADDR_TRIGGER);

  // ************************************************************
  // Control register
  // ************************************************************
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (reg_wr && (addr == ADDR_CONTROL)) begin
      ctrl_next = reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= REG_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ************************************************************
  // Measurement sequencer
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STEP,
    ST_WAIT
  } mcr_state_t;

  mcr_state_t state_reg;
  mcr_state_t state_next;
  logic [2:0] slot_reg;
  logic [2:0] slot_next;
  // Settings are latched per pass so a control write mid-pass cannot mix modes
  logic [7:0] pass_ctrl_reg;
  logic [7:0] pass_ctrl_next;
  logic conv_req_next;
  mcr_conv_req_t conv_cmd_reg;
  mcr_conv_req_t conv_cmd_next;
  logic result_we;

  always_comb begin
    state_next = state_reg;
    slot_next = slot_reg;
    pass_ctrl_next = pass_ctrl_reg;
    conv_cmd_next = conv_cmd_reg;
    conv_req_next = 1'b0;
    result_we = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        // Triggers while a pass runs are ignored
        if (trigger_wr) begin
          state_next = ST_STEP;
          slot_next = SLOT_TINT;
          pass_ctrl_next = ctrl_reg;
        end
      end
      ST_STEP: begin
        if (slot_enabled(pass_ctrl_reg, slot_reg)) begin
          state_next = ST_WAIT;
          conv_req_next = 1'b1;
          conv_cmd_next.kind = slot_kind(pass_ctrl_reg, slot_reg);
          conv_cmd_next.slot = slot_reg;
        end else if (slot_reg != SLOT_VCC) begin
          slot_next = slot_reg + 3'h1;
        end else if (pass_ctrl_reg[CTRL_SINGLE_BIT]) begin
          state_next = ST_IDLE;
        end else begin
          // Repeated mode starts the next pass and never drops busy
          slot_next = SLOT_TINT;
          pass_ctrl_next = ctrl_reg;
        end
      end
      ST_WAIT: begin
        conv_req_next = !conv_done;
        if (conv_done) begin
          result_we = 1'b1;
          if (slot_reg != SLOT_VCC) begin
            state_next = ST_STEP;
            slot_next = slot_reg + 3'h1;
          end else if (pass_ctrl_reg[CTRL_SINGLE_BIT]) begin
            state_next = ST_IDLE;
          end else begin
            state_next = ST_STEP;
            slot_next = SLOT_TINT;
            pass_ctrl_next = ctrl_reg;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      slot_reg <= SLOT_TINT;
      pass_ctrl_reg <= REG_RESET;
      conv_req <= 1'b0;
      conv_cmd_reg <= '0;
    end else begin
      state_reg <= state_next;
      slot_reg <= slot_next;
      pass_ctrl_reg <= pass_ctrl_next;
      conv_req <= conv_req_next;
      conv_cmd_reg <= conv_cmd_next;
    end
  end

  assign conv_cmd = conv_cmd_reg;
  assign busy = (state_reg != ST_IDLE);

  // ************************************************************
  // Result formatting
  // ************************************************************
  logic [12:0] temp_code;
  logic [15:0] supply_code;
  logic is_remote;
  logic [7:0] fmt_hi;
  logic [7:0] fmt_lo;

  always_comb begin
    temp_code = conv_res.value[12:0];
    if (pass_ctrl_reg[CTRL_UNIT_BIT]) begin
      temp_code = conv_res.value[12:0] + KELVIN_OFFSET;
    end
    // Supply arrives as an absolute code; the stored value is above 2.5 V
    supply_code = {1'b0, conv_res.value} - VCC_OFFSET;
    is_remote = (conv_cmd_reg.kind == MK_REMOTE);
    fmt_hi = 8'h00;
    fmt_lo = 8'h00;
    unique case (conv_cmd_reg.kind)
      MK_TINT, MK_REMOTE: begin
        fmt_hi = {1'b1, conv_res.sensor_short && is_remote,
                  conv_res.sensor_open && is_remote, temp_code[12:8]};
        fmt_lo = temp_code[7:0];
      end
      MK_SUPPLY: begin
        fmt_hi = {1'b1, supply_code[15], supply_code[13:8]};
        fmt_lo = supply_code[7:0];
      end
      default: begin
        fmt_hi = {1'b1, conv_res.sign, conv_res.value[13:8]};
        fmt_lo = conv_res.value[7:0];
      end
    endcase
  end

  // ************************************************************
  // Result registers and fresh flags
  // ************************************************************
  logic [7:0] res_hi_reg [NUM_SLOTS];
  logic [7:0] res_hi_next [NUM_SLOTS];
  logic [7:0] res_lo_reg [NUM_SLOTS];
  logic [7:0] res_lo_next [NUM_SLOTS];
  logic [5:0] fresh;

  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      res_hi_next[i] = res_hi_reg[i];
      res_lo_next[i] = res_lo_reg[i];
      if (rd_result_hi && (rd_slot == 3'(i))) begin
        res_hi_next[i][7] = 1'b0;
      end
      // Applied after the clear so a result landing on a read is not lost
      if (result_we && (conv_cmd_reg.slot == 3'(i))) begin
        res_hi_next[i] = fmt_hi;
        res_lo_next[i] = fmt_lo;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        res_hi_reg[i] <= REG_RESET;
        res_lo_reg[i] <= REG_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        res_hi_reg[i] <= res_hi_next[i];
        res_lo_reg[i] <= res_lo_next[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      fresh[i] = res_hi_reg[i][7];
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  logic [7:0] status_val;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  assign status_val = {1'b0, fresh, busy};

  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      if (addr == ADDR_STATUS || addr == ADDR_TRIGGER) begin
        rdata_next = status_val;
      end else if (addr == ADDR_CONTROL) begin
        rdata_next = ctrl_reg;
      end else if (addr < ADDR_RESULT_FIRST) begin
        rdata_next = 8'h00;
      end else if (addr[0]) begin
        rdata_next = res_lo_reg[rd_slot];
      end else begin
        rdata_next = res_hi_reg[rd_slot];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= REG_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule : mcr_monitor_ctrl

/* File: rtl/mcr_pkg.sv */
/*
  Constants, field layouts and carrier types of the monitor control and
  result-formatting block.
  Assumes a byte-wide register port behind the serial bus and an external
  converter front end that takes one measurement request at a time.
*/
// Summary of operation
// - Control bit 7 picks Celsius or Kelvin.
// - Control bit 6 picks repeated or single pass.
// - Mode 00 measures internal temperature only.
// - Mode 01 measures first input pair only.
// - Mode 10 measures second input pair only.
// - Mode 11 measures everything the set defines.
// - Set codes 000 to 011 choose measurements.
// - Set codes 100 to 111 choose measurements.
// - Voltage high byte: fresh, sign, bits 13:8.
// - Voltage low byte holds result bits 7:0.
// - New result sets its fresh flag.
// - Reading a high byte clears its fresh flag.
// - Temperature high byte: fresh, short, open, 12:8.
// - Short flag only for remote temperature results.
// - Open flag only for remote temperature results.
// - Supply result is offset by 2.5 volts.
// - Trigger write starts; trigger read returns status.
// - Reset clears every register to zero.
// - Repeated mode keeps busy high after trigger.
package mcr_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_TRIGGER = 4'h2;
  localparam logic [3:0] ADDR_RESULT_FIRST = 4'h4;
  localparam logic [2:0] SLOT_BASE = 3'h2;
  localparam int NUM_SLOTS = 6;
  localparam logic [2:0] SLOT_TINT = 3'h0;
  localparam logic [2:0] SLOT_IN1 = 3'h1;
  localparam logic [2:0] SLOT_IN2 = 3'h2;
  localparam logic [2:0] SLOT_IN3 = 3'h3;
  localparam logic [2:0] SLOT_IN4 = 3'h4;
  localparam logic [2:0] SLOT_VCC = 3'h5;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CTRL_UNIT_BIT = 7;
  localparam int CTRL_SINGLE_BIT = 6;
  localparam int CTRL_PAIR_HI = 4;
  localparam int CTRL_PAIR_LO = 3;
  localparam int CTRL_SET_HI = 2;
  localparam int CTRL_SET_LO = 0;
  localparam logic [1:0] PAIR_TINT_ONLY = 2'h0;
  localparam logic [1:0] PAIR_FIRST = 2'h1;
  localparam logic [1:0] PAIR_SECOND = 2'h2;
  localparam logic [1:0] PAIR_ALL = 2'h3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FRESH_LSB = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int VOLT_W = 14;
  localparam int TEMP_W = 13;
  // 273.125 K in sixteenths of a degree
  localparam logic [12:0] KELVIN_OFFSET = 13'h1112;
  // 2.5 V in steps of 305.18 uV
  localparam logic [15:0] VCC_OFFSET = 16'h2000;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef enum logic [2:0] {
    MK_TINT,
    MK_SINGLE,
    MK_DIFF,
    MK_REMOTE,
    MK_SUPPLY
  } mcr_kind_t;

  typedef struct packed {
    mcr_kind_t kind;
    logic [2:0] slot;
  } mcr_conv_req_t;

  typedef struct packed {
    logic [14:0] value;
    logic sign;
    logic sensor_short;
    logic sensor_open;
  } mcr_conv_res_t;

endpackage : mcr_pkg

/* File: verif/mcr_conv_model.sv */
/*
  Converter front end model for the monitor bench.
  Assumes one held request at a time; seed and slow come from the bench.
*/
`timescale 1ns/1ps
module mcr_conv_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Request side
  input wire logic conv_req,
  input wire mcr_pkg::mcr_conv_req_t conv_cmd,
  output logic conv_done,
  output mcr_pkg::mcr_conv_res_t conv_res,
  // Bench control
  input wire logic [17:0] seed,
  input wire logic slow
);
  import mcr_pkg::*;
  int wait_cnt;
  logic [17:0] junk;
  // Idle bus churns so a late sample never matches
  assign conv_res = conv_done ? mcr_conv_res_t'(seed ^ (18'(conv_cmd.slot) << 3))
    : mcr_conv_res_t'(junk);
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_done <= 1'b0;
      wait_cnt <= 0;
      junk <= 18'h00000;
    end else begin
      junk <= ~junk ^ 18'(wait_cnt);
      conv_done <= 1'b0;
      if (conv_req && !conv_done) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt >= (slow ? 6 : 0)) begin
          conv_done <= 1'b1;
          wait_cnt <= 0;
        end
      end
    end
  end
endmodule : mcr_conv_model

/* File: verif/mcr_monitor_ctrl_asserts.sv */
/*
  Port checker of the monitor control block.
  Assumes the single clk domain and the async reset of the block.
*/
`timescale 1ns/1ps
module mcr_monitor_ctrl_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Converter front end
  input wire logic conv_req,
  input wire mcr_pkg::mcr_conv_req_t conv_cmd,
  input wire logic conv_done,
  input wire mcr_pkg::mcr_conv_res_t conv_res,
  // Status
  input wire logic busy
);
  import mcr_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_reset_idle;
    $fell(reset) |-> !busy && !conv_req && reg_rdata == REG_RESET;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle");
  property p_trig_start;
    reg_wr && reg_addr[3:0] == ADDR_TRIGGER && !busy |=> busy;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("no start");
  property p_stat_read;
    reg_rd && (reg_addr[3:0] == ADDR_STATUS || reg_addr[3:0] == ADDR_TRIGGER)
      |=> !reg_rdata[7] && reg_rdata[STAT_BUSY_BIT] == $past(busy);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("bad status");
  property p_req_hold;
    conv_req && !conv_done |=> conv_req && $stable(conv_cmd);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("req moved");
  property p_req_drop;
    conv_req && conv_done |=> !conv_req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("req kept");
  property p_req_busy;
    conv_req |-> busy;
  endproperty
  a_req_busy: assert property (p_req_busy) else $error("req idle");
  property p_tint_slot;
    conv_req && conv_cmd.kind == MK_TINT |-> conv_cmd.slot == SLOT_TINT;
  endproperty
  a_tint_slot: assert property (p_tint_slot) else $error("tint slot");
  property p_vcc_slot;
    conv_req && conv_cmd.kind == MK_SUPPLY |-> conv_cmd.slot == SLOT_VCC;
  endproperty
  a_vcc_slot: assert property (p_vcc_slot) else $error("vcc slot");
  property p_pair_slot;
    conv_req && (conv_cmd.kind == MK_REMOTE || conv_cmd.kind == MK_DIFF)
      |-> conv_cmd.slot == SLOT_IN1 || conv_cmd.slot == SLOT_IN3;
  endproperty
  a_pair_slot: assert property (p_pair_slot) else $error("pair slot");
endmodule : mcr_monitor_ctrl_asserts

bind mcr_monitor_ctrl mcr_monitor_ctrl_asserts u_asserts (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .conv_req(conv_req), .conv_cmd(conv_cmd),
  .conv_done(conv_done), .conv_res(conv_res), .busy(busy));

/* File: verif/mcr_monitor_ctrl_tb.sv */
/*
  Self-checking bench of the monitor control block.
  Assumes the converter model answers every request with seeded data.
*/
`timescale 1ns/1ps
module mcr_monitor_ctrl_tb;
  import mcr_pkg::*;
  logic clk, reset, reg_wr, reg_rd, conv_req, conv_done, busy, slow;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, c;
  logic [17:0] seed;
  mcr_conv_req_t conv_cmd;
  mcr_conv_res_t conv_res;
  logic [7:0] exp_hi[6] = '{6{8'h00}};
  logic [7:0] exp_lo[6] = '{6{8'h00}};
  int num_errors, cmp_count;
  // Kind per slot and set code; -1 means unused
  int kt[6][8] = '{'{8{0}}, '{1, 2, 2, 3, 3, 3, 2, 1}, '{1, -1, -1, -1, -1, -1, -1, 1},
    '{3, 3, 1, 1, 2, 3, 2, 1}, '{-1, -1, 1, 1, -1, -1, -1, 1}, '{8{4}}};

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  mcr_monitor_ctrl dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_req(conv_req),
    .conv_cmd(conv_cmd), .conv_done(conv_done), .conv_res(conv_res), .busy(busy));
  mcr_conv_model u_conv (.clk(clk), .reset(reset), .conv_req(conv_req), .conv_cmd(conv_cmd),
    .conv_done(conv_done), .conv_res(conv_res), .seed(seed), .slow(slow));

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Upper address nibble is random: the map must alias
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = {4'($urandom), a};
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk($sformatf("reg %h", a), reg_rdata, e);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = {4'($urandom), a};
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n == 5000) begin
      num_errors++;
      report_and_stop();
    end
  endtask : wait_idle

  task automatic run_model(input logic [7:0] cc, input logic [17:0] sd);
    int k;
    logic [17:0] r;
    logic [12:0] t;
    logic [15:0] v;
    logic en;
    for (int s = 0; s < 6; s++) begin
      k = kt[s][cc[2:0]];
      en = (s == 0) ? cc[4] == cc[3] : (s < 3) ? cc[3] : (s < 5) ? cc[4] : cc[4] & cc[3];
      r = sd ^ (18'(s) << 3);
      t = r[15:3] + (cc[7] ? KELVIN_OFFSET : 13'h0000);
      v = {1'b0, r[17:3]} - VCC_OFFSET;
      if (en && k >= 0) begin
        case (k)
          0, 3: exp_hi[s] = {1'b1, k == 3 && r[1], k == 3 && r[0], t[12:8]};
          4: exp_hi[s] = {1'b1, v[15], v[13:8]};
          default: exp_hi[s] = {1'b1, r[2], r[16:11]};
        endcase
        exp_lo[s] = (k == 0 || k == 3) ? t[7:0] : (k == 4) ? v[7:0] : r[10:3];
      end
    end
  endtask : run_model

  task automatic check_all();
    logic [7:0] st;
    st = 8'h00;
    for (int s = 0; s < 6; s++) st[s + 1] = exp_hi[s][7];
    rd(ADDR_STATUS, st);
    rd(ADDR_TRIGGER, st);
    for (int s = 0; s < 6; s++) begin
      rd(4'(4 + 2 * s), exp_hi[s]);
      exp_hi[s][7] = 1'b0;
      rd(4'(5 + 2 * s), exp_lo[s]);
      rd(4'(4 + 2 * s), exp_hi[s]);
    end
  endtask : check_all

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    seed = 18'h00000;
    slow = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    void'($urandom(32'hBA7B));
    repeat (3) @(negedge clk);
    reset = 1'b0;
    check_all();
    rd(ADDR_CONTROL, REG_RESET);
    rd(4'h3, REG_RESET);
    $display("Test reset done");
    seed = 18'($urandom);
    wr(ADDR_TRIGGER, 8'hA5);
    for (int n = 0; n < 200; n++) begin
      @(negedge clk);
      chk("busy", {7'h00, busy}, 8'h01);
    end
    // Single mode ends the run after the next pass, which picks up the new setting
    wr(ADDR_CONTROL, 8'h40);
    wait_idle();
    run_model(8'h40, seed);
    check_all();
    $display("Test repeat done");
    for (int i = 0; i < 12; i++) begin
      c = {1'($urandom), 2'h2, (i < 8) ? 2'h3 : 2'(i - 8), (i < 8) ? 3'(i) : 3'($urandom)};
      seed = 18'($urandom);
      slow = 1'($urandom);
      wr(ADDR_CONTROL, c);
      rd(ADDR_CONTROL, c);
      wr(4'(4 + 2 * ($urandom % 6)), 8'hFF);
      wr(ADDR_TRIGGER, 8'($urandom));
      wait_idle();
      run_model(c, seed);
      check_all();
      $display("Test pass %0d done", i);
    end
    // Reset in mid-run must also clear written control and results
    wr(ADDR_CONTROL, 8'h1F);
    wr(ADDR_TRIGGER, 8'h00);
    repeat (20) @(negedge clk);
    chk("busy", {7'h00, busy}, 8'h01);
    reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    exp_hi = '{6{8'h00}};
    exp_lo = '{6{8'h00}};
    check_all();
    rd(ADDR_CONTROL, REG_RESET);
    $display("Test mid reset done");
    report_and_stop();
  end
endmodule : mcr_monitor_ctrl_tb
